/* core/kwi_pkg.sv */
// Purpose: shared constants and types for the keypad wake interrupt block
// Assumes: avalon-mm byte addressing with 32-bit data, 8-bit registers
// Notes:   offsets are byte addresses, one word per register
package kwi_pkg;
  localparam int unsigned NUM_PINS     = 4;
  localparam int unsigned REG_W        = 8;
  localparam int unsigned ADDR_W       = 4;
  localparam logic [3:0]  OFF_STATUS   = 4'h0;
  localparam logic [3:0]  OFF_PIN_EN   = 4'h4;
  localparam logic [3:0]  OFF_POLARITY = 4'h8;
  localparam logic [3:0]  OFF_POWER    = 4'hc;
  localparam int unsigned BIT_MODE     = 0;
  localparam int unsigned BIT_IRQ_EN   = 1;
  localparam int unsigned BIT_ACK      = 2;
  localparam int unsigned BIT_FLAG     = 3;
  localparam logic [7:0]  RST_STATUS   = 8'h00;
  localparam logic [7:0]  RST_PIN_EN   = 8'h00;
  localparam logic [7:0]  RST_POLARITY = 8'h00;
  localparam logic [31:0] RD_UNMAPPED  = 32'h0000_0000;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic              read;
    logic              write;
    logic [31:0]       writedata;
    logic [3:0]        byteenable;
  } kwi_bus_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } kwi_bus_rsp_t;

  typedef enum logic [1:0] {
    KWI_BUS_IDLE = 2'b00,
    KWI_BUS_DONE = 2'b01
  } kwi_bus_state_t;
endpackage : kwi_pkg

/* core/kwi_sync.sv */
// Purpose: two-flop synchroniser for a vector of pin inputs
// Assumes: inputs are asynchronous to clock_i
// Notes:   first stage feeds only the second stage
`timescale 1ns/10ps
module kwi_sync #(
  parameter int unsigned WIDTH = 4
) (
  input  wire logic             clock_i,
  input  wire logic             rst_b_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;
endmodule // kwi_sync

/* core/kwi_pin_detect.sv */
// Purpose: per-pin polarity-aware edge and level detect
// Assumes: pin input already synchronised
// Notes:   edge armed only after deasserted level seen while enabled
`timescale 1ns/10ps
module kwi_pin_detect (
  input  wire logic clock_i,
  input  wire logic rst_b_i,
  input  wire logic pin_i,
  input  wire logic enable_i,
  input  wire logic polarity_i,
  input  wire logic mode_i,
  output logic      detect_o,
  output logic      asserted_o
);
  logic armed_reg;
  logic armed_next;
  wire  active = pin_i ~^ polarity_i;

  // arming replaces a raw previous-sample register: the deasserted sample
  // of the previous cycle must have been taken while enabled
  assign armed_next = enable_i & ~active;
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      armed_reg <= 1'b0;
    end else begin
      armed_reg <= armed_next;
    end
  end

  assign asserted_o = enable_i & active;
  // falling: 1 then 0; rising: 0 then 1
  assign detect_o   = asserted_o & (armed_reg | mode_i);
endmodule // kwi_pin_detect

/* core/kwi_top.sv */
// Purpose: keypad wake interrupt block with avalon-mm register slave
// Assumes: 250 MHz clock_i, synchronous active-low reset
// Notes:   low-power modes are signalled by power-mode register inputs
`timescale 1ns/10ps
// Functional notes
// - pin enable bit 1 makes its input a source; 0 ignores it
// - polarity bit 0 means falling/low, 1 means rising/high
// - mode bit 0 detects edges only, 1 edges and levels
// - flag at bit 3 reads detection status; writes leave it
// - acknowledge bit 2 write-one clears flag, always reads zero
// - irq enable bit 1 gates flag onto the interrupt request
// - status bits 7 to 4 read zero, writes ignored
// - falling edge is one sample high then one sample low
// - rising edge is one sample low then one sample high
// - edge needs the input first seen at deasserted level
// - wait mode keeps operating and can wake the processor
// - stop3 detects asynchronously and can wake the processor
// - stop1/stop2 disable block; wake returns to reset state
// - background debug mode behaves exactly as run mode
// - polarity 1 turns enabled pin pull-up into pull-down
// - one shared flag and one interrupt request line only
// - edge mode: edge sets flag, acknowledge clears it unless an edge comes in the same cycle
// - level mode: acknowledge clears only if all enabled inputs deasserted
module kwi_top #(
  parameter int unsigned NUM_PINS = kwi_pkg::NUM_PINS
) (
  input  wire logic                       clock_i,
  input  wire logic                       rst_b_i,
  input  wire logic [kwi_pkg::ADDR_W-1:0] avs_address_i,
  input  wire logic                       avs_read_i,
  input  wire logic                       avs_write_i,
  input  wire logic [31:0]                avs_writedata_i,
  input  wire logic [3:0]                 avs_byteenable_i,
  output logic      [31:0]                avs_readdata_o,
  output logic                            avs_waitrequest_o,
  input  wire logic [NUM_PINS-1:0]        keypad_input_pin_i,
  input  wire logic                       debug_halt_i,
  output logic                            irq_o,
  output logic                            wake_o,
  output logic      [NUM_PINS-1:0]        pull_down_sel_o
);
  // refuse pin counts that the 8-bit registers cannot serve
  if (NUM_PINS < 1 || NUM_PINS > kwi_pkg::REG_W) begin : g_bad_pins
    $error("kwi_top: NUM_PINS must lie in 1..8");
  end

  // registers
  logic [7:0]          pin_en_reg;
  logic [7:0]          polarity_reg;
  logic                mode_reg;
  logic                irq_en_reg;
  logic                flag_reg;
  logic                flag_next;
  logic [1:0]          power_reg;
  logic [31:0]         rdata_reg;
  logic                irq_reg;
  logic                wake_reg;
  logic [NUM_PINS-1:0] pull_dn_reg;
  kwi_pkg::kwi_bus_state_t bus_state_reg;

  kwi_pkg::kwi_bus_req_t req;
  assign req = '{address:    avs_address_i,
                 read:       avs_read_i,
                 write:      avs_write_i,
                 writedata:  avs_writedata_i,
                 byteenable: avs_byteenable_i};

  // power mode encodings: 0 run/wait/debug, 1 stop3, 2 stop1/stop2
  localparam logic [1:0] PWR_RUN   = 2'h0;
  localparam logic [1:0] PWR_STOP3 = 2'h1;
  localparam logic [1:0] PWR_DEEP  = 2'h2;

  // bus decode: every access takes one wait cycle, answered in done state
  wire       bus_req   = req.read | req.write;
  wire       accept    = bus_req & (bus_state_reg == kwi_pkg::KWI_BUS_IDLE);
  wire       wr_lane0  = accept & req.write & req.byteenable[0];
  wire       wr_status = wr_lane0 & (req.address == kwi_pkg::OFF_STATUS);
  wire       wr_pin_en = wr_lane0 & (req.address == kwi_pkg::OFF_PIN_EN);
  wire       wr_pol    = wr_lane0 & (req.address == kwi_pkg::OFF_POLARITY);
  wire       wr_power  = wr_lane0 & (req.address == kwi_pkg::OFF_POWER);
  wire [7:0] wbyte     = req.writedata[7:0];
  wire       ack_wr    = wr_status & wbyte[kwi_pkg::BIT_ACK];

  // deep stop holds the block in reset; leaving it finds reset values
  wire deep_stop = (power_reg == PWR_DEEP);
  wire blk_rst_b = rst_b_i & ~deep_stop;

  // per-pin detection
  wire [NUM_PINS-1:0] pin_sync;
  wire [NUM_PINS-1:0] pin_detect;
  wire [NUM_PINS-1:0] pin_asserted;

  kwi_sync #(.WIDTH(NUM_PINS)) u_sync (
    .clock_i (clock_i),
    .rst_b_i (blk_rst_b),
    .async_i (keypad_input_pin_i),
    .sync_o  (pin_sync)
  );

  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++) begin : g_pin
      kwi_pin_detect u_det (
        .clock_i    (clock_i),
        .rst_b_i    (blk_rst_b),
        .pin_i      (pin_sync[g]),
        .enable_i   (pin_en_reg[g]),
        .polarity_i (polarity_reg[g]),
        .mode_i     (mode_reg),
        .detect_o   (pin_detect[g]),
        .asserted_o (pin_asserted[g])
      );
    end
  endgenerate

  wire any_detect   = |pin_detect;
  wire any_asserted = |pin_asserted;
  // level mode refuses the clear while any enabled input is asserted
  wire ack_clears   = ack_wr & (~mode_reg | ~any_asserted);

  // set wins over clear; debug halt does not alter detection
  assign flag_next = any_detect | (flag_reg & ~ack_clears);

  // stop3: combinational path from raw pins so waking needs no clock
  wire [NUM_PINS-1:0] raw_active =
    keypad_input_pin_i ~^ polarity_reg[NUM_PINS-1:0];
  wire async_wake_c = (power_reg == PWR_STOP3) & irq_en_reg &
                      |(raw_active & pin_en_reg[NUM_PINS-1:0]);

  wire [7:0] status_rd = {4'h0, flag_reg, 1'b0, irq_en_reg, mode_reg};
  wire [31:0] rd_mux =
    (req.address == kwi_pkg::OFF_STATUS)   ? {24'h0, status_rd} :
    (req.address == kwi_pkg::OFF_PIN_EN)   ? {24'h0, pin_en_reg} :
    (req.address == kwi_pkg::OFF_POLARITY) ? {24'h0, polarity_reg} :
    (req.address == kwi_pkg::OFF_POWER)    ? {30'h0, power_reg} :
    kwi_pkg::RD_UNMAPPED;

  // power register only resets with the true reset
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      power_reg <= PWR_RUN;
    end else if (wr_power) begin
      power_reg <= wbyte[1:0];
    end
  end

  always_ff @(posedge clock_i) begin
    if (!blk_rst_b) begin
      pin_en_reg   <= kwi_pkg::RST_PIN_EN;
      polarity_reg <= kwi_pkg::RST_POLARITY;
      mode_reg     <= kwi_pkg::RST_STATUS[kwi_pkg::BIT_MODE];
      irq_en_reg   <= kwi_pkg::RST_STATUS[kwi_pkg::BIT_IRQ_EN];
      flag_reg     <= kwi_pkg::RST_STATUS[kwi_pkg::BIT_FLAG];
    end else begin
      flag_reg <= flag_next;
      if (wr_status) begin
        mode_reg   <= wbyte[kwi_pkg::BIT_MODE];
        irq_en_reg <= wbyte[kwi_pkg::BIT_IRQ_EN];
      end
      if (wr_pin_en) begin
        pin_en_reg <= wbyte;
      end
      if (wr_pol) begin
        polarity_reg <= wbyte;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      bus_state_reg <= kwi_pkg::KWI_BUS_IDLE;
      rdata_reg     <= 32'h0;
    end else begin
      unique case (bus_state_reg)
        kwi_pkg::KWI_BUS_IDLE: begin
          if (bus_req) begin
            bus_state_reg <= kwi_pkg::KWI_BUS_DONE;
            rdata_reg     <= req.read ? rd_mux : 32'h0;
          end
        end
        kwi_pkg::KWI_BUS_DONE: begin
          bus_state_reg <= kwi_pkg::KWI_BUS_IDLE;
        end
        default: begin
          bus_state_reg <= kwi_pkg::KWI_BUS_IDLE;
        end
      endcase
    end
  end

  // waitrequest high except in the answer cycle
  logic wait_reg;
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      wait_reg <= 1'b1;
    end else begin
      wait_reg <= ~accept;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!blk_rst_b) begin
      irq_reg     <= 1'b0;
      wake_reg    <= 1'b0;
      pull_dn_reg <= '0;
    end else begin
      irq_reg     <= flag_next & irq_en_reg;
      wake_reg    <= flag_next & irq_en_reg;
      pull_dn_reg <= pin_en_reg[NUM_PINS-1:0] &
                     polarity_reg[NUM_PINS-1:0];
    end
  end

  assign avs_readdata_o    = rdata_reg;
  assign avs_waitrequest_o = wait_reg;
  assign irq_o             = irq_reg;
  // the only combinational output: stop3 wake cannot wait for a clock
  assign wake_o            = wake_reg | async_wake_c;
  assign pull_down_sel_o   = pull_dn_reg;

  logic unused_dbg;
  assign unused_dbg = debug_halt_i;

  // assertions
  property p_ack_edge_clear;
    @(posedge clock_i) disable iff (!rst_b_i)
      (ack_wr && !mode_reg && !any_detect && !deep_stop) |=> !flag_reg;
  endproperty
  a_ack_edge_clear: assert property (p_ack_edge_clear)
    else $error("ack in edge mode did not clear flag");

  property p_level_hold;
    @(posedge clock_i) disable iff (!rst_b_i)
      (flag_reg && mode_reg && any_asserted && !deep_stop) |=> flag_reg;
  endproperty
  a_level_hold: assert property (p_level_hold)
    else $error("flag cleared while input asserted in level mode");

  property p_detect_sets;
    @(posedge clock_i) disable iff (!rst_b_i)
      (any_detect && !deep_stop) |=> flag_reg;
  endproperty
  a_detect_sets: assert property (p_detect_sets)
    else $error("detection did not set flag");

  property p_irq_gate;
    @(posedge clock_i) disable iff (!rst_b_i)
      irq_o |-> $past(irq_en_reg);
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("irq raised while masked");

  property p_irq_follows;
    @(posedge clock_i) disable iff (!rst_b_i)
      (flag_next && irq_en_reg && !deep_stop) |=> irq_o;
  endproperty
  a_irq_follows: assert property (p_irq_follows)
    else $error("set flag with enable gave no irq");

  property p_upper_zero;
    @(posedge clock_i) disable iff (!rst_b_i)
      (accept && req.read && req.address == kwi_pkg::OFF_STATUS)
        |=> (avs_readdata_o[7:4] == 4'h0) && !avs_readdata_o[2];
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("status unused or ack bit read nonzero");

  property p_disabled_quiet;
    @(posedge clock_i) disable iff (!rst_b_i)
      (pin_en_reg == 8'h00 && !mode_reg) |-> !any_detect;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("detection with no pins enabled");

  property p_deep_reset;
    @(posedge clock_i) disable iff (!rst_b_i)
      deep_stop |=> (pin_en_reg == 8'h00) && !flag_reg && !irq_en_reg;
  endproperty
  a_deep_reset: assert property (p_deep_reset)
    else $error("deep stop left state out of reset");

  property p_one_wait;
    @(posedge clock_i) disable iff (!rst_b_i)
      accept |=> !avs_waitrequest_o ##1 avs_waitrequest_o;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("bus answer not one cycle after accept");

  c_flag_set: cover property (@(posedge clock_i) disable iff (!rst_b_i)
    !flag_reg ##1 flag_reg);
  c_level_refuse: cover property (@(posedge clock_i) disable iff (!rst_b_i)
    ack_wr && mode_reg && any_asserted);
  c_irq: cover property (@(posedge clock_i) disable iff (!rst_b_i)
    $rose(irq_o));
  c_stop3_wake: cover property (@(posedge clock_i) disable iff (!rst_b_i)
    async_wake_c);
endmodule // kwi_top

/* tb/kwi_key_model.sv */
// Purpose: key switches on the keypad inputs, one switch per pin
// Assumes: pull level comes from the block's pull-down select
// Notes:   a pressed key shorts the pin to the rail opposite its pull
`timescale 1ns/10ps
module kwi_key_model #(
  parameter int unsigned NUM_PINS = 4
) (
  input  wire logic [NUM_PINS-1:0] press_i,
  input  wire logic [NUM_PINS-1:0] pull_down_i,
  output logic      [NUM_PINS-1:0] pin_o
);
  // released pin rests at its pull level, never left undriven
  assign pin_o = pull_down_i ~^ press_i;
endmodule // kwi_key_model

/* tb/tb_top.sv */
// Purpose: self-checking bench for the keypad wake interrupt block
// Assumes: bus answer found by polling waitrequest, byte addressed registers
// Notes:   register rows first, then detection and power cases
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  mismatches++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_top;
  logic        clock_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic [3:0]  avs_address_i = 4'h0;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0]  avs_byteenable_i = 4'h0;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic [3:0]  keypad_input_pin_i;
  logic        debug_halt_i = 1'b0;
  logic        irq_o;
  logic        wake_o;
  logic [3:0]  pull_down_sel_o;
  logic [3:0]  press = 4'h0;
  int          mismatches = 0;
  int          n_checks = 0;
  // address, write data, expected read back
  localparam logic [19:0] ROWS [7] = '{
    {kwi_pkg::OFF_STATUS,   8'hf3, 8'h03},
    {kwi_pkg::OFF_STATUS,   8'h00, 8'h00},
    {kwi_pkg::OFF_PIN_EN,   8'ha5, 8'ha5},
    {kwi_pkg::OFF_POLARITY, 8'h5a, 8'h5a},
    {kwi_pkg::OFF_PIN_EN,   8'h00, 8'h00},
    {kwi_pkg::OFF_POLARITY, 8'h00, 8'h00},
    {4'h1,                  8'hff, 8'h00}};

  always #2 clock_i = ~clock_i;

  kwi_top i_dut (
    .clock_i            (clock_i),
    .rst_b_i            (rst_b_i),
    .avs_address_i      (avs_address_i),
    .avs_read_i         (avs_read_i),
    .avs_write_i        (avs_write_i),
    .avs_writedata_i    (avs_writedata_i),
    .avs_byteenable_i   (avs_byteenable_i),
    .avs_readdata_o     (avs_readdata_o),
    .avs_waitrequest_o  (avs_waitrequest_o),
    .keypad_input_pin_i (keypad_input_pin_i),
    .debug_halt_i       (debug_halt_i),
    .irq_o              (irq_o),
    .wake_o             (wake_o),
    .pull_down_sel_o    (pull_down_sel_o)
  );

  kwi_key_model i_keys (
    .press_i     (press),
    .pull_down_i (pull_down_sel_o),
    .pin_o       (keypad_input_pin_i)
  );

  task automatic test_done();
    if (mismatches == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // waits for the answer without assuming its latency
  task automatic bus_wait();
    int n;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    if (n >= 50) begin
      mismatches++;
      $display("CHECK FAILED waitrequest exp 0 got %h", avs_waitrequest_o);
    end
  endtask

  task automatic bus_wr(input logic [3:0] a, input logic [7:0] d,
                        input logic [3:0] be = 4'h1);
    @(posedge clock_i);
    avs_address_i    <= a;
    avs_writedata_i  <= {24'h0, d};
    avs_byteenable_i <= be;
    avs_write_i      <= 1'b1;
    bus_wait();
    avs_write_i      <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clock_i);
    avs_address_i <= a;
    avs_read_i    <= 1'b1;
    bus_wait();
    `CHK("readdata", {24'h0, e}, avs_readdata_o)
    avs_read_i    <= 1'b0;
  endtask

  task automatic key(input logic [3:0] m);
    @(posedge clock_i);
    press <= m;
  endtask

  // two sync flops plus flag and request stages settle well inside this
  task automatic irq_is(input logic e);
    repeat (10) @(posedge clock_i);
    `CHK("irq_o", e, irq_o)
  endtask

  initial begin
    repeat (20000) @(posedge clock_i);
    mismatches++;
    test_done();
  end

  initial begin
    repeat (8) @(posedge clock_i);
    rst_b_i <= 1'b1;
    rd_chk(kwi_pkg::OFF_STATUS, 8'h00);
    rd_chk(kwi_pkg::OFF_PIN_EN, 8'h00);
    rd_chk(kwi_pkg::OFF_POLARITY, 8'h00);
    `CHK("irq_o", 1'b0, irq_o)
    for (int i = 0; i < 7; i++) begin
      bus_wr(ROWS[i][19:16], ROWS[i][15:8]);
      rd_chk(ROWS[i][19:16], ROWS[i][7:0]);
    end
    bus_wr(kwi_pkg::OFF_STATUS, 8'hff, 4'h0);
    rd_chk(kwi_pkg::OFF_STATUS, 8'h00);
    // init order: mask, polarity, enable, acknowledge, unmask
    bus_wr(kwi_pkg::OFF_STATUS, 8'h00);
    bus_wr(kwi_pkg::OFF_POLARITY, 8'h00);
    bus_wr(kwi_pkg::OFF_PIN_EN, 8'h01);
    bus_wr(kwi_pkg::OFF_STATUS, 8'h04);
    bus_wr(kwi_pkg::OFF_STATUS, 8'h02);
    key(4'h1);
    irq_is(1'b1);
    `CHK("wake_o", 1'b1, wake_o)
    bus_wr(kwi_pkg::OFF_STATUS, 8'h02);
    rd_chk(kwi_pkg::OFF_STATUS, 8'h0a);
    key(4'h0);
    irq_is(1'b1);
    bus_wr(kwi_pkg::OFF_STATUS, 8'h06);
    rd_chk(kwi_pkg::OFF_STATUS, 8'h02);
    key(4'h2);
    irq_is(1'b0);
    key(4'h0);
    // rising polarity flips the pull, debug halt must change nothing
    debug_halt_i <= 1'b1;
    bus_wr(kwi_pkg::OFF_POLARITY, 8'h01);
    repeat (4) @(posedge clock_i);
    `CHK("pull_down_sel_o", 4'h1, pull_down_sel_o)
    bus_wr(kwi_pkg::OFF_STATUS, 8'h06);
    key(4'h1);
    irq_is(1'b1);
    key(4'h0);
    repeat (4) @(posedge clock_i);
    debug_halt_i <= 1'b0;
    // level mode: acknowledge refused while the key is held
    bus_wr(kwi_pkg::OFF_STATUS, 8'h07);
    key(4'h1);
    irq_is(1'b1);
    bus_wr(kwi_pkg::OFF_STATUS, 8'h07);
    rd_chk(kwi_pkg::OFF_STATUS, 8'h0b);
    key(4'h0);
    repeat (6) @(posedge clock_i);
    bus_wr(kwi_pkg::OFF_STATUS, 8'h07);
    rd_chk(kwi_pkg::OFF_STATUS, 8'h03);
    bus_wr(kwi_pkg::OFF_STATUS, 8'h01);
    key(4'h1);
    irq_is(1'b0);
    rd_chk(kwi_pkg::OFF_STATUS, 8'h09);
    key(4'h0);
    repeat (6) @(posedge clock_i);
    bus_wr(kwi_pkg::OFF_STATUS, 8'h06);
    rd_chk(kwi_pkg::OFF_STATUS, 8'h02);
    // stop3: wake must not wait for the synchroniser
    bus_wr(kwi_pkg::OFF_POWER, 8'h01);
    key(4'h1);
    #1;
    `CHK("wake_o", 1'b1, wake_o)
    key(4'h0);
    bus_wr(kwi_pkg::OFF_POWER, 8'h00);
    bus_wr(kwi_pkg::OFF_STATUS, 8'h06);
    // stop1/stop2 returns pin enable, polarity and status registers to reset
    bus_wr(kwi_pkg::OFF_POWER, 8'h02);
    bus_wr(kwi_pkg::OFF_POWER, 8'h00);
    rd_chk(kwi_pkg::OFF_PIN_EN, 8'h00);
    rd_chk(kwi_pkg::OFF_POLARITY, 8'h00);
    rd_chk(kwi_pkg::OFF_STATUS, 8'h00);
    // second reset in mid-run
    bus_wr(kwi_pkg::OFF_PIN_EN, 8'h0f);
    @(posedge clock_i);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    rst_b_i <= 1'b1;
    rd_chk(kwi_pkg::OFF_PIN_EN, 8'h00);
    test_done();
  end
endmodule // tb_top
